// ---- hw/activity_monitor.sv ----
`timescale 1ns/1ns
module activity_monitor
  import actmon_pkg::*;
#(
  parameter int NPINS = 8
) (
  input  wire logic             clk,                   // Core clock 20 MHz
  input  wire logic             rstn,                  // Sync reset, low
  input  wire logic [7:0]       sfr_addr,              // SFR address
  input  wire logic [7:0]       sfr_wdata,             // SFR write data
  input  wire logic             sfr_wr,                // SFR write strobe
  input  wire logic             sfr_rd,                // SFR read strobe
  output logic      [7:0]       sfr_rdata,             // Registered read
  output logic                  sfr_hit,               // Address claimed
  input  wire logic [NPINS-1:0] monitor_input_pin,     // Chip-select pins
  input  wire logic             host_io_read_strobe_n, // Host read, low
  input  wire logic             host_io_write_strobe_n,// Host write, low
  output logic      [NPINS-1:0] port_input_buffer,     // Pin levels
  output logic                  activity_irq,          // Interrupt to core
  output logic                  activity_irq_priority  // High priority
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NPINS-1:0] activity_enable;
    logic [NPINS-1:0] strobe_qualify;
    logic [NPINS-1:0] active_level_select;
    logic [NPINS-1:0] activity_flags;
    logic             activity_irq_enable;
    logic             activity_irq_priority;
    logic [7:0]       rdata;
    logic             hit;
    logic [NPINS-1:0] pins;
    logic             irq;
  } mon_state_t;

  mon_state_t st;
  mon_state_t next_st;

  logic [NPINS+1:0] sync_in;
  logic [NPINS+1:0] sync_out;
  logic [NPINS-1:0] pin_lvl;
  logic             strobe_ok;
  logic [NPINS-1:0] valid_state;

  initial begin
    if (NPINS < 1 || NPINS > 8) $error("activity_monitor: NPINS 1..8");
  end

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  assign sync_in = {host_io_write_strobe_n, host_io_read_strobe_n,
                    monitor_input_pin};

  // Pins and strobes share one filter so their delays match
  pin_sync #(.WIDTH(NPINS + 2)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .din  (sync_in),
    .dout (sync_out)
  );

  assign pin_lvl   = sync_out[NPINS-1:0];
  // Either strobe low counts as an accompanying host access
  assign strobe_ok = ~sync_out[NPINS] | ~sync_out[NPINS+1];

  // Per-pin valid state: polarity match, optionally qualified
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_valid
      assign valid_state[g] =
        st.activity_enable[g]
        & (pin_lvl[g] == st.active_level_select[g])
        & (~st.strobe_qualify[g] | strobe_ok);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.hit  = 1'b0;
    next_st.rdata = 8'h00;
    next_st.pins = pin_lvl;
    // Register writes
    if (sfr_wr) begin
      unique case (sfr_addr)
        ADDR_ACTIVITY_ENABLE:
          next_st.activity_enable = sfr_wdata[NPINS-1:0];
        ADDR_STROBE_QUALIFY:
          next_st.strobe_qualify = sfr_wdata[NPINS-1:0];
        ADDR_ACTIVE_LEVEL_SELECT:
          next_st.active_level_select = sfr_wdata[NPINS-1:0];
        ADDR_ACTIVITY_FLAGS:
          // Zero bits clear, one bits hold
          next_st.activity_flags =
            st.activity_flags & sfr_wdata[NPINS-1:0];
        ADDR_IRQ_ENABLE_REG:
          next_st.activity_irq_enable = sfr_wdata[ACTIVITY_IRQ_BIT];
        ADDR_IRQ_PRIORITY_REG:
          next_st.activity_irq_priority = sfr_wdata[ACTIVITY_IRQ_BIT];
        default: ;
      endcase
    end
    // Hardware set applied after the clear so a same-cycle event wins
    next_st.activity_flags = next_st.activity_flags | valid_state;
    // Reads are registered; unmapped addresses return zero, no hit
    if (sfr_rd) begin
      next_st.hit = 1'b1;
      unique case (sfr_addr)
        ADDR_ACTIVITY_ENABLE:
          next_st.rdata[NPINS-1:0] = st.activity_enable;
        ADDR_STROBE_QUALIFY:
          next_st.rdata[NPINS-1:0] = st.strobe_qualify;
        ADDR_ACTIVE_LEVEL_SELECT:
          next_st.rdata[NPINS-1:0] = st.active_level_select;
        ADDR_ACTIVITY_FLAGS:
          next_st.rdata[NPINS-1:0] = st.activity_flags;
        ADDR_IRQ_ENABLE_REG:
          next_st.rdata[ACTIVITY_IRQ_BIT] = st.activity_irq_enable;
        ADDR_IRQ_PRIORITY_REG:
          next_st.rdata[ACTIVITY_IRQ_BIT] = st.activity_irq_priority;
        default:
          next_st.hit = 1'b0;
      endcase
    end
    // Only flags of enabled pins reach the core, then the global gate
    next_st.irq = st.activity_irq_enable
                  & |(st.activity_flags & st.activity_enable);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st                     <= '0;
      st.activity_enable     <= REG_RESET[NPINS-1:0];
      st.strobe_qualify      <= REG_RESET[NPINS-1:0];
      st.active_level_select <= REG_RESET[NPINS-1:0];
      st.activity_flags      <= REG_RESET[NPINS-1:0];
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata             = st.rdata;
  assign sfr_hit               = st.hit;
  assign port_input_buffer     = st.pins;
  assign activity_irq          = st.irq;
  assign activity_irq_priority = st.activity_irq_priority;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_enable_gate;
    @(posedge clk) disable iff (!rstn)
    (st.activity_enable == '0 && $stable(st.activity_enable))
      |-> ##1 (st.activity_flags & ~$past(st.activity_flags)) == '0;
  endproperty
  a_enable_gate: assert property (p_enable_gate)
    else $error("flag set on a disabled pin");

  property p_pins_follow;
    @(posedge clk) disable iff (!rstn)
    1'b1 |=> port_input_buffer == $past(pin_lvl);
  endproperty
  a_pins_follow: assert property (p_pins_follow)
    else $error("input buffer does not follow pin level");

  property p_flag_sets;
    @(posedge clk) disable iff (!rstn)
    (st.activity_enable[0] && pin_lvl[0] == st.active_level_select[0]
     && (!st.strobe_qualify[0] || strobe_ok)) |=> st.activity_flags[0];
  endproperty
  a_flag_sets: assert property (p_flag_sets)
    else $error("valid state did not set flag");

  property p_polarity;
    @(posedge clk) disable iff (!rstn)
    (!st.activity_flags[0] && pin_lvl[0] != st.active_level_select[0])
      |=> !st.activity_flags[0];
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("inactive level set flag");

  property p_qualify;
    @(posedge clk) disable iff (!rstn)
    (!st.activity_flags[0] && st.strobe_qualify[0] && !strobe_ok)
      |=> !st.activity_flags[0];
  endproperty
  a_qualify: assert property (p_qualify)
    else $error("unqualified access set flag");

  property p_irq_gate;
    @(posedge clk) disable iff (!rstn)
    ##1 activity_irq == ($past(st.activity_irq_enable)
      && |($past(st.activity_flags) & $past(st.activity_enable)));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt not gated by enables and flags");

  property p_irq_global;
    @(posedge clk) disable iff (!rstn)
    !st.activity_irq_enable [*2] |-> !activity_irq;
  endproperty
  a_irq_global: assert property (p_irq_global)
    else $error("interrupt while globally disabled");

  property p_write_zero_clears;
    @(posedge clk) disable iff (!rstn)
    (sfr_wr && sfr_addr == ADDR_ACTIVITY_FLAGS && !sfr_wdata[0]
     && !valid_state[0]) |=> !st.activity_flags[0];
  endproperty
  a_write_zero_clears: assert property (p_write_zero_clears)
    else $error("write of zero did not clear flag");

  property p_reset_zero;
    @(posedge clk)
    !rstn |=> (st.activity_enable == '0 && st.strobe_qualify == '0
               && st.active_level_select == '0
               && st.activity_flags == '0);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("registers not zero after reset");
endmodule

// ---- hw/actmon_pkg.sv ----
package actmon_pkg;
  // ----------------------------------------------------------------
  // Register map (core special-function register space)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ACTIVITY_ENABLE       = 8'h92;
  localparam logic [7:0] ADDR_STROBE_QUALIFY        = 8'h93;
  localparam logic [7:0] ADDR_ACTIVE_LEVEL_SELECT   = 8'h94;
  localparam logic [7:0] ADDR_ACTIVITY_FLAGS        = 8'h95;
  localparam logic [7:0] ADDR_IRQ_ENABLE_REG        = 8'hA8;
  localparam logic [7:0] ADDR_IRQ_PRIORITY_REG      = 8'hB8;
  // ----------------------------------------------------------------
  // Field positions, reset values and synchroniser depth
  // ----------------------------------------------------------------
  localparam int         ACTIVITY_IRQ_BIT           = 6;
  localparam logic [7:0] REG_RESET                  = 8'h00;
  localparam int         SYNC_STAGES                = 3;
endpackage

// ---- hw/pin_sync.sv ----
`timescale 1ns/1ns
// ------------------------------------------------------------------
// Three-stage synchroniser with agreement filter
// ------------------------------------------------------------------
module pin_sync
  import actmon_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clk,   // Core clock
  input  wire logic             rstn,  // Sync reset, active low
  input  wire logic [WIDTH-1:0] din,   // Asynchronous inputs
  output logic      [WIDTH-1:0] dout   // Filtered, synchronised level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  initial begin
    if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
  end

  // The first stage is read only by the second; output moves once the
  // second and third stages agree, so a one-cycle glitch is ignored
  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) next_st.q[i] = st.s3[i];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.q;
endmodule

// ---- tb/periph_model.sv ----
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Far side: peripheral chip selects and host I/O strobes
// ----------------------------------------------------------------
module periph_model (
  input  wire logic [7:0] cs_level, // Wanted chip-select levels
  input  wire logic [7:0] port_latch, // Port output latch bits
  input  wire logic       rd_req,   // Host read cycle in progress
  input  wire logic       wr_req,   // Host write cycle in progress
  output logic      [7:0] cs_pin,   // Chip-select lines to the monitor
  output logic            rd_n,     // Host read strobe, active low
  output logic            wr_n      // Host write strobe, active low
);
  // Open-drain pin: a latch zero sinks the line low whatever the chip
  // select does, so a monitored pin needs its latch at one
  assign cs_pin = cs_level & port_latch;
  // Strobes rest high between host cycles, as their pull-ups do
  assign rd_n   = ~rd_req;
  assign wr_n   = ~wr_req;
endmodule

// ---- tb/testbench.sv ----
`timescale 1ns/1ns
module testbench
  import actmon_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic       clk, rstn, sfr_wr, sfr_rd, sfr_hit, rd_req, wr_req;
  logic       rd_n, wr_n, irq, prio;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, cs_level, pins, pib, latch;
  int         err_count, cmp_count, cyc;
  periph_model far (.cs_level(cs_level), .port_latch(latch),
    .rd_req(rd_req),
    .wr_req(wr_req), .cs_pin(pins), .rd_n(rd_n), .wr_n(wr_n));
  activity_monitor #(.NPINS(8)) dut (.clk(clk), .rstn(rstn),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
    .monitor_input_pin(pins), .host_io_read_strobe_n(rd_n),
    .host_io_write_strobe_n(wr_n), .port_input_buffer(pib),
    .activity_irq(irq), .activity_irq_priority(prio));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1;
    sfr_wr = 1'b0;
  endtask
  // Read answer is registered, so it is taken just after the read edge
  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [7:0] exp, input logic hit);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk);
    #1;
    sfr_rd = 1'b0;
    chk(what, exp, sfr_rdata);
    chk("hit", {7'h00, hit}, {7'h00, sfr_hit});
  endtask
  // Synchroniser plus filter needs four edges, the registered pins five; eight leaves margin
  task automatic settle();
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rchk("enable", ADDR_ACTIVITY_ENABLE, 8'h00, 1'b1);
    rchk("qualify", ADDR_STROBE_QUALIFY, 8'h00, 1'b1);
    rchk("polarity", ADDR_ACTIVE_LEVEL_SELECT, 8'h00, 1'b1);
    rchk("flags", ADDR_ACTIVITY_FLAGS, 8'h00, 1'b1);
    rchk("irq_en", ADDR_IRQ_ENABLE_REG, 8'h00, 1'b1);
    rchk("irq_prio", ADDR_IRQ_PRIORITY_REG, 8'h00, 1'b1);
    rchk("unmapped", 8'h00, 8'h00, 1'b0);
    $display("reset values done");
  endtask
  // Pin 2 is active too but not enabled, so it must never flag
  task automatic t_low_level();
    wr(ADDR_ACTIVITY_ENABLE, 8'h01);
    cs_level = 8'hFA;
    settle();
    chk("pin levels", 8'hFA, pib);
    rchk("flags", ADDR_ACTIVITY_FLAGS, 8'h01, 1'b1);
    cs_level = 8'hFF;
    settle();
    chk("pin levels", 8'hFF, pib);
    rchk("sticky", ADDR_ACTIVITY_FLAGS, 8'h01, 1'b1);
    wr(ADDR_ACTIVITY_FLAGS, 8'hFF);
    rchk("write one", ADDR_ACTIVITY_FLAGS, 8'h01, 1'b1);
    wr(ADDR_ACTIVITY_FLAGS, 8'hFE);
    rchk("write zero", ADDR_ACTIVITY_FLAGS, 8'h00, 1'b1);
    $display("low level and clear done");
  endtask
  // Pin 1 idles high, which is active once its polarity is high
  task automatic t_qualify();
    wr(ADDR_ACTIVE_LEVEL_SELECT, 8'h02);
    wr(ADDR_STROBE_QUALIFY, 8'h02);
    wr(ADDR_ACTIVITY_ENABLE, 8'h03);
    settle();
    rchk("qualify rb", ADDR_STROBE_QUALIFY, 8'h02, 1'b1);
    rchk("no strobe", ADDR_ACTIVITY_FLAGS, 8'h00, 1'b1);
    rd_req = 1'b1;
    settle();
    rd_req = 1'b0;
    // Released strobe must clear the filter first, or its set beats the
    // following flag clear
    settle();
    rchk("read strobe", ADDR_ACTIVITY_FLAGS, 8'h02, 1'b1);
    wr(ADDR_ACTIVITY_FLAGS, 8'h00);
    settle();
    rchk("cleared", ADDR_ACTIVITY_FLAGS, 8'h00, 1'b1);
    wr_req = 1'b1;
    settle();
    wr_req = 1'b0;
    settle();
    rchk("write strobe", ADDR_ACTIVITY_FLAGS, 8'h02, 1'b1);
    wr(ADDR_ACTIVITY_FLAGS, 8'h00);
    $display("qualify done");
  endtask
  task automatic t_irq();
    wr(ADDR_IRQ_ENABLE_REG, 8'h40);
    cs_level = 8'hFE;
    settle();
    chk("irq", 8'h01, {7'h00, irq});
    wr(ADDR_IRQ_PRIORITY_REG, 8'h40);
    #50;
    chk("priority", 8'h01, {7'h00, prio});
    rchk("prio rb", ADDR_IRQ_PRIORITY_REG, 8'h40, 1'b1);
    cs_level = 8'hFF;
    wr(ADDR_ACTIVITY_ENABLE, 8'h02);
    #100;
    chk("irq source off", 8'h00, {7'h00, irq});
    rchk("flag kept", ADDR_ACTIVITY_FLAGS, 8'h01, 1'b1);
    wr(ADDR_ACTIVITY_ENABLE, 8'h01);
    #100;
    chk("irq source on", 8'h01, {7'h00, irq});
    wr(ADDR_IRQ_ENABLE_REG, 8'h00);
    #100;
    chk("irq masked", 8'h00, {7'h00, irq});
    $display("interrupt done");
  endtask
  // Second reset with a flag, an enable and the priority bit all set
  task automatic t_rerun();
    @(posedge clk);
    #1;
    rstn = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk("prio reset", 8'h00, {7'h00, prio});
    chk("irq reset", 8'h00, {7'h00, irq});
    rchk("flags reset", ADDR_ACTIVITY_FLAGS, 8'h00, 1'b1);
    rchk("enable reset", ADDR_ACTIVITY_ENABLE, 8'h00, 1'b1);
    $display("mid-run reset done");
  endtask
  // LED on pin 7 sinks its line low; pin 7 is not monitored, so no flag
  task automatic t_led();
    wr(ADDR_ACTIVITY_ENABLE, 8'h01);
    latch = 8'h7F;
    settle();
    chk("led on pin", 8'h7F, pib);
    rchk("led no flag", ADDR_ACTIVITY_FLAGS, 8'h00, 1'b1);
    latch = 8'hFF;
    settle();
    chk("led off pin", 8'hFF, pib);
    wr(ADDR_ACTIVITY_ENABLE, 8'h00);
    $display("led done");
  endtask
  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Whole run is about 175 cycles; a hang is cut at 3000
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      $display("timeout reached");
      give_verdict();
    end
  end
  initial begin
    {rstn, sfr_wr, sfr_rd, rd_req, wr_req} = 5'h00;
    {sfr_addr, sfr_wdata} = 16'h0000;
    cs_level = 8'hFF;
    latch = 8'hFF;
    {err_count, cmp_count, cyc} = '0;
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    t_reset();
    t_low_level();
    t_qualify();
    t_irq();
    t_rerun();
    t_led();
    give_verdict();
  end
endmodule
